// >>> ebt_map.vh
// Purpose: Register map, field positions, reset values and prescaler taps of the 8-bit timer.
// Assumes: APB with 32-bit data; each register takes one aligned word at four times its index.
// Notes:   Included by the prescaler and timer design files, the assertions and the bench.
`ifndef EBT_MAP_VH
`define EBT_MAP_VH

// =====================================================================
// Register indices and byte addresses
`define EBT_IDX_CONTROL     8'h16
`define EBT_IDX_COMPARE     8'h17
`define EBT_IDX_DIV_CONFIG  8'h18
`define EBT_IDX_STATUS      8'h19
`define EBT_ADDR_CONTROL    8'h58
`define EBT_ADDR_COMPARE    8'h5C
`define EBT_ADDR_DIV_CONFIG 8'h60
`define EBT_ADDR_STATUS     8'h64

// =====================================================================
// Control, config and status register fields
`define EBT_MODE_LSB        0
`define EBT_MODE_MSB        1
`define EBT_SRC_LSB         2
`define EBT_SRC_MSB         4
`define EBT_RUN_BIT         5
`define EBT_CFG_FIRST_BIT   0
`define EBT_CFG_CLKSRC_BIT  1
`define EBT_STAT_DIV_BIT    8
`define EBT_STAT_PWM_BIT    9

// =====================================================================
// Mode and source codes
`define EBT_MODE_TIMER      2'h0
`define EBT_MODE_RSVD       2'h1
`define EBT_MODE_DIVIDER    2'h2
`define EBT_MODE_PWM        2'h3
`define EBT_SRC_SLOWEST     3'h0
`define EBT_SRC_EXTERNAL    3'h7

// =====================================================================
// Reset values
`define EBT_RST_CONTROL     8'h00
`define EBT_RST_COMPARE     8'hFF
`define EBT_RST_DIV_CONFIG  2'h0

// =====================================================================
// Prescaler tap exponents of the fast clock, and the slow clock divide
`define EBT_TAP_000         4'hB
`define EBT_TAP_001         4'h7
`define EBT_TAP_010         4'h5
`define EBT_TAP_011         4'h3
`define EBT_TAP_100         4'h2
`define EBT_TAP_101         4'h1
`define EBT_TAP_110         4'h0
`define EBT_SLOW_DIV_LAST   3'h7

`endif

// >>> ebt_pin_sync.v
// Purpose: Brings an asynchronous pin into the pclk domain and marks its edges.
// Assumes: Pin pulses last several pclk periods.
// Notes:   A level counts once the second and third stages agree.
`timescale 1ns/1ps

module ebt_pin_sync
(
  input  wire pclk,
  input  wire presetn,
  input  wire pin_in,
  output reg  rise,
  output reg  fall
);

  // ===================================================================
  // Three-stage synchroniser and agreed level
  reg [2:0] stage;
  reg       level;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage <= 3'h0;
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end
    else
    begin
      stage <= {stage[1:0], pin_in};
      rise  <= 1'b0;
      fall  <= 1'b0;
      // Only stages two and three are compared; stage one may be metastable.
      if ((stage[1] == stage[2]) && (stage[2] != level))
      begin
        level <= stage[2];
        rise  <= stage[2];
        fall  <= ~stage[2];
      end
    end
  end

endmodule // ebt_pin_sync

// >>> ebt_prescaler.v
// Purpose: Divider chain that turns the fast clock or slow clock into count enables.
// Assumes: pclk is the fast clock; the slow clock arrives as synchronised rising edges.
// Notes:   The enable is registered, so it lags the selected tap by one cycle.
`timescale 1ns/1ps
`include "ebt_map.vh"

module ebt_prescaler
#(
  parameter DIV_WIDTH = 13
)
(
  input  wire       pclk,
  input  wire       presetn,
  input  wire [2:0] source_clock_select,
  input  wire       divider_first_stage_select,
  input  wire       divider_clock_source_select,
  input  wire       slow_rise,
  output reg        tick
);

  // ===================================================================
  // Tap exponent of each source code
  function [3:0] tap_exp;
    input [2:0] code;
    begin
      case (code)
        3'h0:    tap_exp = `EBT_TAP_000;
        3'h1:    tap_exp = `EBT_TAP_001;
        3'h2:    tap_exp = `EBT_TAP_010;
        3'h3:    tap_exp = `EBT_TAP_011;
        3'h4:    tap_exp = `EBT_TAP_100;
        3'h5:    tap_exp = `EBT_TAP_101;
        default: tap_exp = `EBT_TAP_110;
      endcase
    end
  endfunction

  // ===================================================================
  // Free-running chain and slow clock divide
  reg  [DIV_WIDTH-1:0] chain;
  reg  [2:0]           slow_cnt;
  wire [3:0]           exp_sel = tap_exp(source_clock_select)
                                 + {3'h0, divider_first_stage_select};
  wire [DIV_WIDTH-1:0] mask = ({{(DIV_WIDTH-1){1'b0}}, 1'b1} << exp_sel)
                              - {{(DIV_WIDTH-1){1'b0}}, 1'b1};
  wire                 fast_tick = ((chain & mask) == mask);
  wire                 slow_tick = slow_rise && (slow_cnt == `EBT_SLOW_DIV_LAST);
  reg                  next_tick;

  always @*
  begin
    if ((source_clock_select == `EBT_SRC_SLOWEST) && divider_clock_source_select)
      next_tick = slow_tick;
    else if (source_clock_select == `EBT_SRC_EXTERNAL)
      next_tick = 1'b0;
    else
      next_tick = fast_tick;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chain    <= {DIV_WIDTH{1'b0}};
      slow_cnt <= 3'h0;
      tick     <= 1'b0;
    end
    else
    begin
      chain <= chain + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
      if (slow_rise)
        slow_cnt <= slow_cnt + 3'h1;
      tick <= next_tick;
    end
  end

endmodule // ebt_prescaler

// >>> ebt_timer.v
// Purpose: Eight-bit timer/counter with timer, event, divider and PWM modes, APB slave.
// Assumes: pclk is the fast clock; stop_mode_entry is a pulse from the standby controller.
// Notes:   One wait state on every APB access; unmapped addresses answer with pslverr.
`timescale 1ns/1ps
`include "ebt_map.vh"

module ebt_timer
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        event_input_pin,
  input  wire        low_freq_clock,
  input  wire        stop_mode_entry,
  output reg         divider_output_pin,
  output reg         pwm_output_pin,
  output reg         timer_match_interrupt
);

  // ===================================================================
  // Address decode
  localparam SEL_NONE    = 3'h0;
  localparam SEL_CONTROL = 3'h1;
  localparam SEL_COMPARE = 3'h2;
  localparam SEL_CONFIG  = 3'h3;
  localparam SEL_STATUS  = 3'h4;

  localparam [7:0] RST_CONTROL = `EBT_RST_CONTROL;

  function [2:0] reg_sel;
    input [7:0] addr;
    begin
      case (addr)
        `EBT_ADDR_CONTROL:    reg_sel = SEL_CONTROL;
        `EBT_ADDR_COMPARE:    reg_sel = SEL_COMPARE;
        `EBT_ADDR_DIV_CONFIG: reg_sel = SEL_CONFIG;
        `EBT_ADDR_STATUS:     reg_sel = SEL_STATUS;
        default:              reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // ===================================================================
  // State
  reg       run_control;
  reg [2:0] source_clock_select;
  reg [1:0] operating_mode_select;
  reg [7:0] timer_compare_value;
  reg       divider_first_stage_select;
  reg       divider_clock_source_select;
  reg [7:0] count;
  reg [7:0] pwm_active;

  wire       tick;
  wire       event_rise;
  wire       event_fall;
  wire       slow_rise;
  wire [7:0] count_inc   = count + 8'h01;
  wire       match_next  = (count_inc == timer_compare_value);
  wire       access      = psel && penable && pready;
  wire [2:0] sel         = reg_sel(paddr);
  wire       write_ctl   = access && pwrite && (sel == SEL_CONTROL);
  wire       write_cmp   = access && pwrite && (sel == SEL_COMPARE);
  wire       write_cfg   = access && pwrite && (sel == SEL_CONFIG);
  wire       ext_source  = (source_clock_select == `EBT_SRC_EXTERNAL);

  // ===================================================================
  // Pin synchronisers and prescaler
  ebt_pin_sync u_event_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (event_input_pin),
    .rise    (event_rise),
    .fall    (event_fall)
  );

  ebt_pin_sync u_slow_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (low_freq_clock),
    .rise    (slow_rise),
    .fall    ()
  );

  ebt_prescaler #(
    .DIV_WIDTH (13)
  ) u_prescaler
  (
    .pclk                        (pclk),
    .presetn                     (presetn),
    .source_clock_select         (source_clock_select),
    .divider_first_stage_select  (divider_first_stage_select),
    .divider_clock_source_select (divider_clock_source_select),
    .slow_rise                   (slow_rise),
    .tick                        (tick)
  );

  // ===================================================================
  // APB handshake and read data
  reg [31:0] next_prdata;

  always @*
  begin
    next_prdata = 32'h0000_0000;
    case (sel)
      SEL_CONTROL:
      begin
        // Bits 6 and 7 have no storage and read as zero.
        next_prdata[`EBT_RUN_BIT]                 = run_control;
        next_prdata[`EBT_SRC_MSB:`EBT_SRC_LSB]    = source_clock_select;
        next_prdata[`EBT_MODE_MSB:`EBT_MODE_LSB]  = operating_mode_select;
      end
      SEL_COMPARE:
        next_prdata[7:0] = timer_compare_value;
      SEL_CONFIG:
      begin
        next_prdata[`EBT_CFG_FIRST_BIT]  = divider_first_stage_select;
        next_prdata[`EBT_CFG_CLKSRC_BIT] = divider_clock_source_select;
      end
      SEL_STATUS:
      begin
        next_prdata[7:0]               = count;
        next_prdata[`EBT_STAT_DIV_BIT] = divider_output_pin;
        next_prdata[`EBT_STAT_PWM_BIT] = pwm_output_pin;
      end
      default:
        next_prdata = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      // The answer comes one cycle into the access phase, so data is registered.
      if (psel && penable && !pready)
      begin
        pready  <= 1'b1;
        pslverr <= (sel == SEL_NONE);
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      end
      else
      begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ===================================================================
  // Software registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_control                 <= RST_CONTROL[`EBT_RUN_BIT];
      source_clock_select         <= RST_CONTROL[`EBT_SRC_MSB:`EBT_SRC_LSB];
      operating_mode_select       <= RST_CONTROL[`EBT_MODE_MSB:`EBT_MODE_LSB];
      timer_compare_value         <= `EBT_RST_COMPARE;
      divider_first_stage_select  <= 1'b0;
      divider_clock_source_select <= 1'b0;
    end
    else
    begin
      // Standby entry wins over a software start in the same cycle: halting is safe.
      if (stop_mode_entry)
        run_control <= 1'b0;
      else if (write_ctl)
        run_control <= pwdata[`EBT_RUN_BIT];
      if (write_ctl)
      begin
        source_clock_select   <= pwdata[`EBT_SRC_MSB:`EBT_SRC_LSB];
        operating_mode_select <= pwdata[`EBT_MODE_MSB:`EBT_MODE_LSB];
      end
      if (write_cmp)
        timer_compare_value <= pwdata[7:0];
      if (write_cfg)
      begin
        divider_first_stage_select  <= pwdata[`EBT_CFG_FIRST_BIT];
        divider_clock_source_select <= pwdata[`EBT_CFG_CLKSRC_BIT];
      end
    end
  end

  // ===================================================================
  // Counter and outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count                 <= 8'h00;
      pwm_active            <= `EBT_RST_COMPARE;
      divider_output_pin    <= 1'b1;
      pwm_output_pin        <= 1'b1;
      timer_match_interrupt <= 1'b0;
    end
    else
    begin
      timer_match_interrupt <= 1'b0;
      if (!run_control)
      begin
        // Stopped: counter held at zero, pins idle high, shadow follows software.
        count              <= 8'h00;
        divider_output_pin <= 1'b1;
        pwm_output_pin     <= 1'b1;
        pwm_active         <= timer_compare_value;
      end
      else
      begin
        case (operating_mode_select)
          `EBT_MODE_TIMER:
          begin
            divider_output_pin <= 1'b1;
            pwm_output_pin     <= 1'b1;
            if (ext_source)
            begin
              if (event_rise)
                count <= count_inc;
              else if (event_fall && (count == timer_compare_value))
              begin
                count                 <= 8'h00;
                timer_match_interrupt <= 1'b1;
              end
            end
            else if (tick)
            begin
              if (match_next)
              begin
                count                 <= 8'h00;
                timer_match_interrupt <= 1'b1;
              end
              else
                count <= count_inc;
            end
          end
          `EBT_MODE_DIVIDER:
          begin
            pwm_output_pin <= 1'b1;
            if (tick)
            begin
              if (match_next)
              begin
                count                 <= 8'h00;
                divider_output_pin    <= ~divider_output_pin;
                timer_match_interrupt <= 1'b1;
              end
              else
                count <= count_inc;
            end
          end
          `EBT_MODE_PWM:
          begin
            divider_output_pin <= 1'b1;
            if (tick)
            begin
              count <= count_inc;
              if (count == 8'hFF)
              begin
                // Overflow closes the cycle and takes the new compare value.
                pwm_output_pin        <= 1'b1;
                timer_match_interrupt <= 1'b1;
                pwm_active            <= timer_compare_value;
              end
              else if (count_inc == pwm_active)
                pwm_output_pin <= 1'b0;
            end
          end
          default:
          begin
            // The reserved mode holds the counter and keeps both pins high.
            divider_output_pin <= 1'b1;
            pwm_output_pin     <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // ebt_timer

// >>> ebt_timer_sva.sv
// Purpose: Port-level assertions for the eight-bit timer.
// Assumes: Every control write crosses the APB, so the run state is mirrored here.
// Notes:   Bound to ebt_timer after the endmodule.
`timescale 1ns/1ps
`include "ebt_map.vh"

module ebt_timer_sva
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        stop_mode_entry,
  input wire        divider_output_pin,
  input wire        pwm_output_pin,
  input wire        timer_match_interrupt
);
  reg  [7:0] ctrl_seen;
  reg  [1:0] idle_cnt;
  wire       ctrl_wr;
  wire       mapped;

  assign ctrl_wr = psel && penable && pready && pwrite && (paddr == `EBT_ADDR_CONTROL);
  assign mapped  = (paddr == `EBT_ADDR_CONTROL) || (paddr == `EBT_ADDR_COMPARE) ||
                   (paddr == `EBT_ADDR_DIV_CONFIG) || (paddr == `EBT_ADDR_STATUS);

  // ====================
  // Mirror of the control register
  // The stop pulse is applied last so that it beats a write in the same cycle.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_seen <= 8'h00;
      idle_cnt  <= 2'h0;
    end
    else
    begin
      if (ctrl_wr)
        ctrl_seen <= {2'h0, pwdata[5:0]};
      if (stop_mode_entry)
        ctrl_seen[5] <= 1'b0;
      if (ctrl_seen[5])
        idle_cnt <= 2'h0;
      else if (idle_cnt != 2'h3)
        idle_cnt <= idle_cnt + 2'h1;
    end
  end

  // ====================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready did not follow one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  err_decode_a: assert property (pready |-> (pslverr == !mapped))
    else $error("pslverr does not match the address decode");
  err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  ctrl_read_a: assert property (
    pready && !pwrite && paddr == `EBT_ADDR_CONTROL |-> prdata == {24'h000000, ctrl_seen})
    else $error("control readback differs from written value");
  idle_pins_a: assert property (
    idle_cnt == 2'h3 |-> divider_output_pin && pwm_output_pin && !timer_match_interrupt)
    else $error("stopped timer drives a pin low or interrupts");
  stop_entry_a: assert property (
    stop_mode_entry |-> ##[1:3] (divider_output_pin && pwm_output_pin && !timer_match_interrupt))
    else $error("stop entry did not halt the timer");
  div_toggle_a: assert property (
    ctrl_seen[5] && ctrl_seen[1:0] == `EBT_MODE_DIVIDER && $changed(divider_output_pin)
    |-> timer_match_interrupt)
    else $error("divider toggle without interrupt");
  pwm_rise_a: assert property (
    ctrl_seen[5] && ctrl_seen[1:0] == `EBT_MODE_PWM && $rose(pwm_output_pin)
    |-> ##[0:1] timer_match_interrupt)
    else $error("pwm overflow without interrupt");
endmodule // ebt_timer_sva

bind ebt_timer ebt_timer_sva chk_u
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stop_mode_entry(stop_mode_entry), .divider_output_pin(divider_output_pin),
  .pwm_output_pin(pwm_output_pin), .timer_match_interrupt(timer_match_interrupt)
);

// >>> ebt_timer_bench.sv
// Purpose: Self-checking bench for the eight-bit timer through its APB registers.
// Assumes: Source 011 ticks every 8 pclk, 010 every 32, slow clock toggles every 20.
// Notes:   Periods are measured between interrupt pulses.
`timescale 1ns/1ps
`include "ebt_map.vh"

module ebt_timer_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        event_input_pin = 1'b0;
  logic        low_freq_clock = 1'b0;
  logic        stop_mode_entry = 1'b0;
  logic        divider_output_pin;
  logic        pwm_output_pin;
  logic        timer_match_interrupt;
  int          n_errors = 0;
  int          checks_done = 0;
  logic [31:0] rdat;
  logic        rerr;

  ebt_timer dut_u
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_input_pin(event_input_pin), .low_freq_clock(low_freq_clock),
    .stop_mode_entry(stop_mode_entry), .divider_output_pin(divider_output_pin),
    .pwm_output_pin(pwm_output_pin), .timer_match_interrupt(timer_match_interrupt)
  );

  always #12.5 pclk = ~pclk;

  always
  begin
    repeat (20) @(posedge pclk);
    low_freq_clock <= ~low_freq_clock;
  end

  // ====================
  // Helpers
  task automatic stop_test;
    $display("checks_done %0d n_errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Reads pready after each edge, so the value seen is the one sampled there.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    check("pready", 32'h1, {31'h0, pready});
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(nm, exp, rdat);
  endtask

  task automatic run_case(input logic [7:0] ctl, input logic [1:0] cfg,
                          input logic [7:0] cmp, input int eg, input int el, input logic fl);
    int   g;
    int   l;
    logic p0;
    apb(1'b1, `EBT_ADDR_DIV_CONFIG, {30'h0, cfg});
    apb(1'b1, `EBT_ADDR_COMPARE, {24'h0, cmp});
    apb(1'b1, `EBT_ADDR_CONTROL, {24'h0, ctl & 8'hDF});
    apb(1'b1, `EBT_ADDR_CONTROL, {24'h0, ctl});
    g = 0;
    l = 0;
    while (timer_match_interrupt !== 1'b1 && g < 5000)
    begin
      @(posedge pclk);
      g++;
    end
    p0 = divider_output_pin;
    g = 0;
    do
    begin
      @(posedge pclk);
      g++;
      l += (pwm_output_pin === 1'b0);
    end
    while (timer_match_interrupt !== 1'b1 && g < 5000);
    check("irq period", eg, g);
    if (el >= 0)
      check("pwm low", el, l);
    check("divider flip", {31'h0, fl}, {31'h0, p0 ^ divider_output_pin});
    apb(1'b1, `EBT_ADDR_CONTROL, {24'h0, ctl & 8'hDF});
    repeat (3) @(posedge pclk);
    rd("idle status", `EBT_ADDR_STATUS, 32'h00000300);
  endtask

  // ====================
  // Tests
  initial
  begin
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("control reset", `EBT_ADDR_CONTROL, 32'h00000000);
    rd("compare reset", `EBT_ADDR_COMPARE, 32'h000000FF);
    rd("config reset", `EBT_ADDR_DIV_CONFIG, 32'h00000000);
    rd("status reset", `EBT_ADDR_STATUS, 32'h00000300);
    apb(1'b1, `EBT_ADDR_CONTROL, 32'h000000C0);
    rd("control high bits", `EBT_ADDR_CONTROL, 32'h00000000);
    apb(1'b1, 8'h70, 32'h000000FF);
    check("unmapped write err", 32'h1, {31'h0, rerr});
    rd("unmapped read", 8'h70, 32'h00000000);
    check("unmapped read err", 32'h1, {31'h0, rerr});
    run_case(8'h2C, 2'h0, 8'h03, 24, -1, 1'b0);
    run_case(8'h2C, 2'h0, 8'h01, 8, -1, 1'b0);
    run_case(8'h2C, 2'h0, 8'hFF, 2040, -1, 1'b0);
    run_case(8'h2C, 2'h1, 8'h03, 48, -1, 1'b0);
    run_case(8'h20, 2'h2, 8'h01, 320, -1, 1'b0);
    run_case(8'h2A, 2'h0, 8'h02, 64, -1, 1'b1);
    run_case(8'h2F, 2'h0, 8'h40, 2048, 1536, 1'b0);
    run_case(8'h33, 2'h0, 8'h40, 1024, 768, 1'b0);
    run_case(8'h37, 2'h0, 8'h40, 512, 384, 1'b0);
    apb(1'b1, `EBT_ADDR_COMPARE, 32'h00000002);
    apb(1'b1, `EBT_ADDR_CONTROL, 32'h0000001C);
    apb(1'b1, `EBT_ADDR_CONTROL, 32'h0000003C);
    for (int i = 0; i < 3; i++)
    begin
      event_input_pin <= 1'b1;
      repeat (10)
      begin
        @(posedge pclk);
        hi += (timer_match_interrupt === 1'b1);
      end
      event_input_pin <= 1'b0;
      repeat (10)
      begin
        @(posedge pclk);
        lo += (timer_match_interrupt === 1'b1);
      end
    end
    check("irq while high", 32'h0, hi);
    check("irq after fall", 32'h1, lo);
    apb(1'b0, `EBT_ADDR_STATUS, 32'h00000000);
    check("event count", 32'h1, {24'h0, rdat[7:0]});
    apb(1'b1, `EBT_ADDR_CONTROL, 32'h0000001C);
    apb(1'b1, `EBT_ADDR_CONTROL, 32'h0000000D);
    apb(1'b1, `EBT_ADDR_CONTROL, 32'h0000002D);
    repeat (40) @(posedge pclk);
    rd("reserved mode count", `EBT_ADDR_STATUS, 32'h00000300);
    rd("reserved mode stored", `EBT_ADDR_CONTROL, 32'h0000002D);
    apb(1'b1, `EBT_ADDR_CONTROL, 32'h0000000D);
    apb(1'b1, `EBT_ADDR_CONTROL, 32'h0000000F);
    apb(1'b1, `EBT_ADDR_CONTROL, 32'h0000002F);
    repeat (20) @(posedge pclk);
    check("pwm before stop", 32'h0, {31'h0, pwm_output_pin});
    stop_mode_entry <= 1'b1;
    @(posedge pclk);
    stop_mode_entry <= 1'b0;
    repeat (3) @(posedge pclk);
    rd("run after stop", `EBT_ADDR_CONTROL, 32'h0000000F);
    rd("count after stop", `EBT_ADDR_STATUS, 32'h00000300);
    stop_test();
  end

  initial
  begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    stop_test();
  end
endmodule // ebt_timer_bench
